// ### core/exc_entry_bank.sv
// Exception entry, prioritisation, register banking and debug halt.
// Assumes the pipeline offers exceptions as levels and accepts a redirect pulse.
`timescale 1ns/1ns
module exc_entry_bank
   import exc_pkg::*;
#(
   parameter int W = exc_pkg::WORD_W  // Data width.
)(
   // Clock and reset.
   input  wire logic          clock_i,
   input  wire logic          rst_b_i,
   // Exception sources.
   input  wire logic          fast_interrupt_request_i,
   input  wire logic          irq_request_i,
   input  wire logic          abort_i,
   input  wire logic          undef_i,
   input  wire logic          software_trap_instruction_i,
   input  wire logic          instr_done_i,   // Current instruction has retired.
   input  wire logic [W-1:0]  return_addr_i,  // Address to resume at.
   // Register file port.
   input  wire logic          rf_we_i,
   input  wire logic [3:0]    rf_waddr_i,
   input  wire logic [W-1:0]  rf_wdata_i,
   input  wire logic [3:0]    rf_raddr_i,
   input  wire logic          sw_we_i,        // Status word write.
   input  wire logic [W-1:0]  sw_wdata_i,
   // Multiply unit.
   input  wire logic          mul_acc_i,
   input  wire logic          mul_signed_i,
   input  wire logic [W-1:0]  mul_a_i,
   input  wire logic [W-1:0]  mul_b_i,
   input  wire logic [63:0]   mul_acc_in_i,
   // Bus request from the pipeline.
   input  wire logic [W-1:0]  bus_addr_i,
   input  wire logic [1:0]    bus_size_i,     // 0 byte, 1 half, 2 word.
   input  wire logic [W-1:0]  fetch_addr_i,   // Pipeline's next fetch address.
   // Debug test port.
   input  wire logic          dbg_cmd_valid_i,
   input  wire logic [1:0]    dbg_cmd_i,
   input  wire logic [W-1:0]  dbg_data_i,
   input  wire logic [3:0]    dbg_raddr_i,
   // Outputs.
   output logic [W-1:0]       rf_rdata_o,
   output logic [W-1:0]       dbg_rdata_o,
   output logic [W-1:0]       status_word_o,
   output logic [W-1:0]       saved_status_o,
   output logic               redirect_o,     // One-cycle pulse with vector.
   output logic [W-1:0]       fetch_addr_o,
   output logic               debug_halt_o,
   output logic [63:0]        mul_result_o,
   output logic [W-1:0]       bus_addr_o,
   output logic [3:0]         bus_lanes_o
);

   // ****************************************************************
   // Storage: 31 general registers and 6 status words.
   // ****************************************************************
   logic [W-1:0] user_reg [0:15];          // User bank, index 15 is the PC.
   logic [W-1:0] fast_hi_reg [8:12];       // Fast interrupt copies of 8..12.
   logic [W-1:0] bank_sp_reg [1:5];        // Banked stack pointers.
   logic [W-1:0] bank_lr_reg [1:5];        // Banked link registers.
   logic [W-1:0] saved_sw_reg [1:5];       // Five saved status words.
   logic [W-1:0] status_word_reg;          // Current status word.
   logic [W-1:0] bkpt_reg;                 // Breakpoint address.
   logic [W-1:0] watch_reg;                // Watchpoint address.
   logic [1:0]   fsync_reg, isync_reg;     // Request synchronisers.

   typedef enum logic [1:0] {ST_RUN, ST_ENTRY, ST_HALT} state_type;
   state_type state_reg, state_next;
   logic [1:0] entry_cnt_reg;
   bank_type   pend_bank_reg;

   // ****************************************************************
   // Bank decode.
   // ****************************************************************
   wire  [4:0] mode_w = status_word_reg[SW_MODE_LO +: 5];
   bank_type   bank_w;
   assign bank_w = (mode_w == MODE_FAST)  ? BANK_FAST  :
                   (mode_w == MODE_IRQ)   ? BANK_IRQ   :
                   (mode_w == MODE_TRAP)  ? BANK_TRAP  :
                   (mode_w == MODE_ABORT) ? BANK_ABORT :
                   (mode_w == MODE_UNDEF) ? BANK_UNDEF : BANK_USER;

   // Read a register through the current mode's banking.
   function automatic logic [W-1:0] bank_read(input logic [3:0] a);
      logic [W-1:0] v;
      v = user_reg[a];
      if (bank_w != BANK_USER && a == 4'hd) begin
         v = bank_sp_reg[bank_w];
      end else if (bank_w != BANK_USER && a == 4'he) begin
         v = bank_lr_reg[bank_w];
      end else if (bank_w == BANK_FAST && a >= 4'h8 && a <= 4'hc) begin
         v = fast_hi_reg[a];
      end
      return v;
   endfunction : bank_read

   // ****************************************************************
   // Exception priority.
   // ****************************************************************
   wire fast_req_w = fsync_reg[1] & ~status_word_reg[SW_FAST_MASK];
   wire irq_req_w  = isync_reg[1] & ~status_word_reg[SW_IRQ_MASK];
   // Interrupts wait for the current instruction to retire; a long instruction
   // is what stretches latency toward the worst-case bounds.
   wire take_w     = (state_reg == ST_RUN) &
                     (abort_i | undef_i | software_trap_instruction_i |
                      ((fast_req_w | irq_req_w) & instr_done_i));
   // Abort first, then fast, then normal; a normal request waits as long
   // as fast ones keep coming, which is accepted behaviour.
   bank_type sel_bank_w;
   assign sel_bank_w = abort_i    ? BANK_ABORT :
                       fast_req_w ? BANK_FAST  :
                       irq_req_w  ? BANK_IRQ   :
                       undef_i    ? BANK_UNDEF : BANK_TRAP;

   wire [4:0] new_mode_w = (pend_bank_reg == BANK_FAST)  ? MODE_FAST  :
                           (pend_bank_reg == BANK_IRQ)   ? MODE_IRQ   :
                           (pend_bank_reg == BANK_ABORT) ? MODE_ABORT :
                           (pend_bank_reg == BANK_UNDEF) ? MODE_UNDEF : MODE_TRAP;
   wire [W-1:0] vec_w = (pend_bank_reg == BANK_FAST)  ? VEC_FAST  :
                        (pend_bank_reg == BANK_IRQ)   ? VEC_IRQ   :
                        (pend_bank_reg == BANK_ABORT) ? VEC_ABORT :
                        (pend_bank_reg == BANK_UNDEF) ? VEC_UNDEF : VEC_TRAP;
   wire entry_done_w = (state_reg == ST_ENTRY) &&
                       (entry_cnt_reg == 2'(ENTRY_CYCLES - 1));

   // Debug match: breakpoint on fetch, watchpoint on data address.
   wire dbg_hit_w = (state_reg == ST_RUN) &
                    ((fetch_addr_i == bkpt_reg) | (bus_addr_i == watch_reg));
   // Only the debug port writes these; software has no path.
   wire bk_wr_w = dbg_cmd_valid_i & (dbg_cmd_i == DBG_WR_BKPT);
   wire wp_wr_w = dbg_cmd_valid_i & (dbg_cmd_i == DBG_WR_WATCH);
   wire resume_w = dbg_cmd_valid_i & (dbg_cmd_i == DBG_RESUME);

   // ****************************************************************
   // State machine: run, exception entry, debug halt.
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (dbg_hit_w) begin
               state_next = ST_HALT;
            end else if (take_w) begin
               state_next = ST_ENTRY;
            end
         end
         ST_ENTRY: begin
            if (entry_done_w) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            if (resume_w) begin
               state_next = ST_RUN;
            end
         end
      endcase
   end

   // Synchronisers: two stages, second stage alone is read.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fsync_reg <= 2'b00;
         isync_reg <= 2'b00;
      end else begin
         fsync_reg <= {fsync_reg[0], fast_interrupt_request_i};
         isync_reg <= {isync_reg[0], irq_request_i};
      end
   end

   // Sequencer state and the entry counter.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg     <= ST_RUN;
         entry_cnt_reg <= 2'b00;
         pend_bank_reg <= BANK_TRAP;
      end else begin
         state_reg     <= state_next;
         entry_cnt_reg <= (state_reg == ST_ENTRY) ? entry_cnt_reg + 2'b01 : 2'b00;
         if (take_w && !dbg_hit_w) begin
            pend_bank_reg <= sel_bank_w;
         end
      end
   end

   // Debug address registers, written only from the test port.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bkpt_reg  <= '1;
         watch_reg <= '1;
      end else begin
         if (bk_wr_w) bkpt_reg <= dbg_data_i;
         if (wp_wr_w) watch_reg <= dbg_data_i;
      end
   end

   // ****************************************************************
   // Register file writes and the entry bookkeeping.
   // ****************************************************************
   // The entry write goes into the new bank, so the old user link survives.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_word_reg <= SW_RESET;
         for (int i = 0; i < 16; i++) user_reg[i] <= '0;
         for (int i = 8; i <= 12; i++) fast_hi_reg[i] <= '0;
         for (int i = 1; i <= 5; i++) begin
            bank_sp_reg[i]  <= '0;
            bank_lr_reg[i]  <= '0;
            saved_sw_reg[i] <= '0;
         end
      end else if (take_w && !dbg_hit_w) begin
         // Save return address and status into the new bank.
         bank_lr_reg[sel_bank_w]  <= return_addr_i;
         saved_sw_reg[sel_bank_w] <= status_word_reg;
      end else if (entry_done_w) begin
         status_word_reg[SW_MODE_LO +: 5] <= new_mode_w;
         status_word_reg[SW_CMP_BIT]      <= 1'b0;
         status_word_reg[SW_IRQ_MASK]     <= 1'b1;
         if (pend_bank_reg == BANK_FAST) status_word_reg[SW_FAST_MASK] <= 1'b1;
      end else if (state_reg == ST_RUN) begin
         if (sw_we_i) begin
            status_word_reg <= sw_wdata_i;
            // Privileged code stays in the 32-bit set.
            if (bank_w != BANK_USER) status_word_reg[SW_CMP_BIT] <= 1'b0;
         end
         if (rf_we_i) begin
            if (bank_w != BANK_USER && rf_waddr_i == 4'hd) begin
               bank_sp_reg[bank_w] <= rf_wdata_i;
            end else if (bank_w != BANK_USER && rf_waddr_i == 4'he) begin
               bank_lr_reg[bank_w] <= rf_wdata_i;
            end else if (bank_w == BANK_FAST && rf_waddr_i >= 4'h8
                         && rf_waddr_i <= 4'hc) begin
               fast_hi_reg[rf_waddr_i] <= rf_wdata_i;
            end else begin
               user_reg[rf_waddr_i] <= rf_wdata_i;
            end
         end
      end
   end

   // ****************************************************************
   // Multiplier and bus lane decode.
   // ****************************************************************
   wire signed [63:0] prod_s_w = $signed(mul_a_i) * $signed(mul_b_i);
   wire        [63:0] prod_u_w = {32'h0, mul_a_i} * {32'h0, mul_b_i};
   wire        [63:0] prod_w   = mul_signed_i ? 64'(prod_s_w) : prod_u_w;
   wire        [63:0] mac_w    = mul_acc_i ? prod_w + mul_acc_in_i : prod_w;
   wire [3:0] lanes_w = (bus_size_i == 2'd0) ? (4'h1 << bus_addr_i[1:0]) :
                        (bus_size_i == 2'd1) ? (bus_addr_i[1] ? 4'hc : 4'h3) :
                        4'hf;

   // ****************************************************************
   // Registered outputs.
   // ****************************************************************
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rf_rdata_o     <= '0;
         dbg_rdata_o    <= '0;
         status_word_o  <= SW_RESET;
         saved_status_o <= '0;
         redirect_o     <= 1'b0;
         fetch_addr_o   <= '0;
         debug_halt_o   <= 1'b0;
         mul_result_o   <= '0;
         bus_addr_o     <= '0;
         bus_lanes_o    <= 4'h0;
      end else begin
         rf_rdata_o     <= bank_read(rf_raddr_i);
         dbg_rdata_o    <= bank_read(dbg_raddr_i);
         status_word_o  <= status_word_reg;
         saved_status_o <= (bank_w == BANK_USER) ? '0 : saved_sw_reg[bank_w];
         redirect_o     <= entry_done_w;
         if (entry_done_w) fetch_addr_o <= vec_w;
         debug_halt_o   <= (state_next == ST_HALT);
         mul_result_o   <= mac_w;
         bus_addr_o     <= {bus_addr_i[W-1:2], 2'b00};
         bus_lanes_o    <= lanes_w;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   // Latency counter from the raw, unsynchronised fast request input to the redirect.
   logic [6:0] lat_cnt_reg;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) lat_cnt_reg <= '0;
      // A masked or halted core is not held to the latency bound.
      else if (redirect_o || !fast_interrupt_request_i ||
               status_word_reg[SW_FAST_MASK] || state_reg == ST_HALT) lat_cnt_reg <= '0;
      else if (lat_cnt_reg != 7'h7f) lat_cnt_reg <= lat_cnt_reg + 7'h01;
   end

   a_fast_over_irq: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      take_w && fast_req_w && !abort_i |-> sel_bank_w == BANK_FAST)
      else $error("Normal interrupt taken over fast one.");
   a_fast_vector: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      entry_done_w && pend_bank_reg == BANK_FAST |=> redirect_o && fetch_addr_o == VEC_FAST)
      else $error("Fast entry did not fetch fast vector.");
   a_entry_wide_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      redirect_o |-> !status_word_reg[SW_CMP_BIT])
      else $error("Exception entry left compressed set on.");
   a_fast_latency: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      lat_cnt_reg <= 7'(LAT_MAX_FULL))
      else $error("Fast interrupt latency exceeded bound.");
   a_min_latency: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      $rose(fast_interrupt_request_i) && state_reg == ST_RUN
      |-> (!(redirect_o && fetch_addr_o == VEC_FAST))[*4])
      else $error("Interrupt entered faster than minimum.");
   a_link_saved: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      take_w && !dbg_hit_w |=> bank_lr_reg[pend_bank_reg] == $past(return_addr_i)
                            && saved_sw_reg[pend_bank_reg] == $past(status_word_reg))
      else $error("Return address or status not saved.");
   a_debug_halt: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      dbg_hit_w |=> debug_halt_o && state_reg == ST_HALT)
      else $error("Debug hit did not halt.");
   a_halt_held: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      debug_halt_o && !resume_w |=> debug_halt_o)
      else $error("Debug halt dropped without resume.");
   a_mul_result: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !mul_acc_i && !mul_signed_i |=>
         mul_result_o == 64'($past(mul_a_i)) * 64'($past(mul_b_i)))
      else $error("Multiply result wrong.");
   a_bkpt_port: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !bk_wr_w |=> $stable(bkpt_reg))
      else $error("Breakpoint changed without debug port.");

endmodule : exc_entry_bank

// ### core/exc_pkg.sv
// Package for the exception entry and register banking unit.
// Assumes a single processor clock and an active-low asynchronous reset.
package exc_pkg;

   // ****************************************************************
   // Widths and counts.
   // ****************************************************************
   localparam int WORD_W        = 32;   // Register and bus width.
   localparam int REG_TOTAL     = 37;   // All registers, banked ones included.
   localparam int REG_GP        = 31;   // General-purpose registers.
   localparam int REG_STATUS    = 6;    // Current plus five saved status words.
   localparam int USER_GP       = 15;   // Registers seen in user mode, the PC aside.
   localparam int FAST_BANK_LO  = 8;    // First register banked by fast interrupt.
   localparam int FAST_BANK_HI  = 12;   // Last register with a fast-only copy; 13 and 14 use the per-mode bank.
   localparam int EXC_KINDS     = 5;    // Exception kinds, one mode each.

   // ****************************************************************
   // Latency figures in processor cycles.
   // ****************************************************************
   localparam int LAT_MAX_FULL  = 50;   // Worst case with load-multiple.
   localparam int LAT_MAX_NOLM  = 42;   // Worst case without load-multiple.
   localparam int LAT_MAX_CMP   = 22;   // Worst case in the compressed set.
   localparam int LAT_MIN       = 5;    // Shortest request to vector fetch.
   localparam int SYNC_STAGES   = 2;    // Synchroniser depth.
   localparam int ENTRY_CYCLES  = LAT_MIN - SYNC_STAGES - 1; // Entry sequence length.

   // ****************************************************************
   // Vector addresses and status word fields.
   // ****************************************************************
   localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
   localparam logic [31:0] VEC_TRAP  = 32'h0000_0008;
   localparam logic [31:0] VEC_ABORT = 32'h0000_0010;
   localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
   localparam logic [31:0] VEC_FAST  = 32'h0000_001c;
   localparam int SW_MODE_LO  = 0;      // Mode field, five bits.
   localparam int SW_CMP_BIT  = 5;      // Compressed-set state bit.
   localparam int SW_FAST_MASK = 6;     // Fast interrupt disable.
   localparam int SW_IRQ_MASK = 7;      // Normal interrupt disable.
   localparam logic [4:0] MODE_USER  = 5'h10;
   localparam logic [4:0] MODE_FAST  = 5'h11;
   localparam logic [4:0] MODE_IRQ   = 5'h12;
   localparam logic [4:0] MODE_TRAP  = 5'h13;
   localparam logic [4:0] MODE_ABORT = 5'h17;
   localparam logic [4:0] MODE_UNDEF = 5'h1b;
   localparam logic [31:0] SW_RESET  = 32'h0000_00d3; // Trap mode, both masked.

   // Debug port commands.
   localparam logic [1:0] DBG_WR_BKPT  = 2'h1;
   localparam logic [1:0] DBG_WR_WATCH = 2'h2;
   localparam logic [1:0] DBG_RESUME   = 2'h3;

   // Bank index of user mode and of each privileged mode.
   typedef enum logic [2:0] {
      BANK_USER, BANK_FAST, BANK_IRQ, BANK_TRAP, BANK_ABORT, BANK_UNDEF
   } bank_type;

endpackage : exc_pkg

// ### tb/irq_dbg_model.sv
// Far-side model: interrupt controller levels and the debug test port.
// Assumes exc_pkg and a unit that fetches the vector with a redirect pulse.
`timescale 1ns/1ns
module irq_dbg_model
   import exc_pkg::*;
(
   // Clock and unit outputs.
   input  wire logic        clock_i,
   input  wire logic        redirect_i,
   input  wire logic [31:0] vector_i,
   // Requests and debug port towards the unit.
   output logic             fast_o,
   output logic             irq_o,
   output logic             dbg_valid_o,
   output logic [1:0]       dbg_cmd_o,
   output logic [31:0]      dbg_data_o
);
   // ***************************************************************
   // Request levels.
   // ***************************************************************
   initial begin
      fast_o = 1'b0;
      irq_o = 1'b0;
      dbg_valid_o = 1'b0;
      dbg_cmd_o = 2'h0;
      dbg_data_o = 32'h0;
   end

   // A level stays up until its own vector is fetched, as a real source would.
   always @(negedge clock_i) begin
      if (redirect_i === 1'b1 && vector_i === VEC_FAST) fast_o <= 1'b0;
      if (redirect_i === 1'b1 && vector_i === VEC_IRQ) irq_o <= 1'b0;
   end

   // Raises the chosen levels off the sampling edge.
   task raise_req(input logic f, input logic i);
      @(negedge clock_i);
      if (f) fast_o = 1'b1;
      if (i) irq_o = 1'b1;
   endtask : raise_req

   // One-cycle command; the data lines then show garbage, not the old value.
   task dbg_send(input logic [1:0] c, input logic [31:0] d);
      @(negedge clock_i);
      dbg_valid_o = 1'b1;
      dbg_cmd_o = c;
      dbg_data_o = d;
      @(negedge clock_i);
      dbg_valid_o = 1'b0;
      dbg_data_o = ~d;
   endtask : dbg_send
endmodule : irq_dbg_model

// ### tb/tb.sv
// Self-checking bench for the exception entry and banking unit.
// Assumes exc_pkg, the unit and the far-side model are compiled first.
`timescale 1ns/1ns
module tb;
   import exc_pkg::*;
   // ***************************************************************
   // Pins, notes and counters.
   // ***************************************************************
   logic        clock_i = 0, rst_b_i = 0, abort_i = 0, undef_i = 0, trap_i = 0;
   logic        rf_we_i = 0, sw_we_i = 0, mul_acc_i = 0, mul_signed_i = 0, done_i = 1;
   logic        fast, irq, dbg_valid, redirect_o, debug_halt_o;
   logic [1:0]  bus_size_i = 0, dbg_cmd;
   logic [3:0]  rf_waddr_i = 0, rf_raddr_i = 0, dbg_raddr_i = 0, bus_lanes_o;
   logic [31:0] ret_i = 0, rf_wdata_i = 0, sw_wdata_i = 0, mul_a_i = 0, mul_b_i = 0;
   logic [31:0] bus_addr_i = 0, fetch_addr_i = 0, dbg_data, rf_rdata_o, dbg_rdata_o;
   logic [31:0] status_word_o, saved_status_o, fetch_addr_o, bus_addr_o, a, b;
   logic [63:0] mul_acc_in_i = 0, mul_result_o, m;
   logic [31:0] exp_vec[$];   // Vectors expected, oldest first.
   int          num_errors = 0, samples_checked = 0, cycles = 0, lat;

   always #2 clock_i = ~clock_i;

   exc_entry_bank i_exc_entry_bank (.clock_i, .rst_b_i, .fast_interrupt_request_i(fast),
      .irq_request_i(irq), .abort_i, .undef_i, .software_trap_instruction_i(trap_i),
      .instr_done_i(done_i), .return_addr_i(ret_i), .rf_we_i, .rf_waddr_i, .rf_wdata_i,
      .rf_raddr_i, .sw_we_i, .sw_wdata_i, .mul_acc_i, .mul_signed_i, .mul_a_i, .mul_b_i,
      .mul_acc_in_i, .bus_addr_i, .bus_size_i, .fetch_addr_i, .dbg_cmd_valid_i(dbg_valid),
      .dbg_cmd_i(dbg_cmd), .dbg_data_i(dbg_data), .dbg_raddr_i, .rf_rdata_o, .dbg_rdata_o,
      .status_word_o, .saved_status_o, .redirect_o, .fetch_addr_o, .debug_halt_o,
      .mul_result_o, .bus_addr_o, .bus_lanes_o);
   irq_dbg_model i_model (.clock_i, .redirect_i(redirect_o), .vector_i(fetch_addr_o),
      .fast_o(fast), .irq_o(irq), .dbg_valid_o(dbg_valid), .dbg_cmd_o(dbg_cmd),
      .dbg_data_o(dbg_data));

   // ***************************************************************
   // Shared tasks.
   // ***************************************************************
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task report_and_stop;
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // Bounded wait; lat counts falling edges until the pulse shows.
   task wait_redir;
      lat = 0;
      do begin
         @(negedge clock_i);
         lat++;
      end while (redirect_o !== 1'b1 && lat < 60);
      if (redirect_o !== 1'b1) num_errors++;
      // Registered status outputs follow the redirect by one cycle.
      @(negedge clock_i);
   endtask : wait_redir

   task rf_wr(input logic [3:0] ad, input logic [31:0] d);
      @(negedge clock_i);
      {rf_we_i, rf_waddr_i, rf_wdata_i} = {1'b1, ad, d};
      @(negedge clock_i);
      rf_we_i = 1'b0;
   endtask : rf_wr

   task rf_rd(input logic [3:0] ad, input logic [31:0] e);
      @(negedge clock_i);
      rf_raddr_i = ad;
      @(negedge clock_i);
      check(rf_rdata_o, e);
   endtask : rf_rd

   task sw_wr(input logic [31:0] d);
      @(negedge clock_i);
      {sw_we_i, sw_wdata_i} = {1'b1, d};
      @(negedge clock_i);
      sw_we_i = 1'b0;
   endtask : sw_wr

   // The oldest note is taken whenever a redirect shows.
   always @(negedge clock_i) begin
      if (redirect_o === 1'b1) begin
         if (exp_vec.size() == 0) check(fetch_addr_o, 64'hdead);
         else check(fetch_addr_o, exp_vec.pop_front());
      end
   end

   // A hang is cut short well above the expected run length.
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ***************************************************************
   // Main sequence.
   // ***************************************************************
   initial begin
      a = $urandom(32'ha6d7);
      repeat (10) @(negedge clock_i);
      rst_b_i = 1'b1;
      @(negedge clock_i);
      check(status_word_o, SW_RESET);
      sw_wr(32'h10);
      for (int k = 0; k < 3; k++) begin
         exp_vec.push_back(k == 0 ? VEC_ABORT : k == 1 ? VEC_UNDEF : VEC_TRAP);
         @(negedge clock_i);
         {abort_i, undef_i, trap_i} = 3'b100 >> k;
         @(negedge clock_i);
         {abort_i, undef_i, trap_i} = 3'b000;
         wait_redir();
         check(status_word_o[4:0], k[1] ? MODE_TRAP : k[0] ? MODE_UNDEF : MODE_ABORT);
         sw_wr(32'h10);
      end
      // Both interrupts at once from the compressed set.
      sw_wr(32'h30);
      a = $urandom;
      b = $urandom;
      ret_i = $urandom & 32'hffff_fffc;
      rf_wr(4'd8, a);
      rf_wr(4'd13, a);
      exp_vec.push_back(VEC_FAST);
      exp_vec.push_back(VEC_IRQ);
      i_model.raise_req(1'b1, 1'b1);
      wait_redir();
      check(lat, LAT_MIN);
      check(status_word_o[7:0], {2'b11, 1'b0, MODE_FAST});
      check(saved_status_o, 32'h30);
      rf_rd(4'd14, ret_i);
      rf_wr(4'd8, b);
      rf_wr(4'd13, b);
      done_i = 1'b0;
      sw_wr(32'h10);
      repeat (3) @(negedge clock_i);
      done_i = 1'b1;
      wait_redir();
      check(lat, ENTRY_CYCLES + 1);
      check(status_word_o[4:0], MODE_IRQ);
      rf_rd(4'd8, a);
      sw_wr(32'h10);
      rf_rd(4'd13, a);
      for (int k = 0; k < 4; k++) begin
         @(negedge clock_i);
         {mul_a_i, mul_b_i, mul_acc_in_i} = {$urandom, $urandom, $urandom, $urandom};
         {mul_acc_i, mul_signed_i} = k[1:0];
         m = k[0] ? longint'($signed(mul_a_i)) * longint'($signed(mul_b_i))
                  : {32'h0, mul_a_i} * {32'h0, mul_b_i};
         @(negedge clock_i);
         check(mul_result_o, m + (k[1] ? mul_acc_in_i : 64'h0));
      end
      for (int k = 0; k < 3; k++) begin
         @(negedge clock_i);
         bus_size_i = k[1:0];
         bus_addr_i = $urandom & (k == 0 ? 32'hffff_ffff : k == 1 ? 32'hffff_fffe : 32'hffff_fffc);
         @(negedge clock_i);
         check(bus_addr_o, bus_addr_i & 32'hffff_fffc);
         check(bus_lanes_o, k == 2 ? 4'hf : (k == 1 ? 4'h3 : 4'h1) << bus_addr_i[1:0]);
      end
      for (int k = 0; k < 2; k++) begin
         i_model.dbg_send(k == 0 ? DBG_WR_BKPT : DBG_WR_WATCH, 32'h0000_0200);
         @(negedge clock_i);
         {fetch_addr_i, bus_addr_i} = k == 0 ? {32'h200, 32'h0} : {32'h0, 32'h200};
         @(negedge clock_i);
         {fetch_addr_i, bus_addr_i, dbg_raddr_i} = {64'h0, 4'd8};
         repeat (2) @(negedge clock_i);
         check(debug_halt_o, 1'b1);
         check(dbg_rdata_o, a);
         i_model.dbg_send(DBG_RESUME, 32'h0);
         repeat (2) @(negedge clock_i);
         check(debug_halt_o, 1'b0);
      end
      check(exp_vec.size(), 0);
      report_and_stop();
   end
endmodule : tb
